// ===== include/tmb_pkg.sv
// constants, field layouts and types of the sixteen-bit timer channel
package tmb_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          CNT_W           = 16;
  localparam int          PSC_W           = 8;

  // register byte addresses
  localparam logic [7:0]  OFS_RUN         = 8'h00;
  localparam logic [7:0]  OFS_MODE        = 8'h04;
  localparam logic [7:0]  OFS_START       = 8'h08;
  localparam logic [7:0]  OFS_CLKGEN      = 8'h0C;
  localparam logic [7:0]  OFS_STATUS      = 8'h10;
  localparam logic [7:0]  OFS_MASK        = 8'h14;
  localparam logic [7:0]  OFS_SNAPSHOT    = 8'h18;
  localparam logic [7:0]  OFS_CMP0        = 8'h1C;
  localparam logic [7:0]  OFS_CMP1        = 8'h20;
  localparam logic [7:0]  OFS_CAP0        = 8'h24;
  localparam logic [7:0]  OFS_CAP1        = 8'h28;

  // run_control fields
  localparam int          RUN_COUNTER_BIT = 0;
  localparam int          RUN_PRESC_BIT   = 2;
  // mode_control fields
  localparam int          MODE_SRC_LSB    = 0;
  localparam int          MODE_SOFTCAP_BIT = 3;
  localparam int          MODE_EXTCAP_BIT = 4;
  // start_control fields
  localparam int          START_TRIG_BIT  = 0;
  localparam int          START_FALL_BIT  = 1;
  localparam int          START_SYNC_BIT  = 2;
  // clockgen_system_config fields
  localparam int          CG_DIV_LSB      = 0;
  localparam int          CG_SRC_BIT      = 4;

  localparam logic [2:0]  SRC_EXTERNAL    = 3'h0;
  localparam logic [2:0]  FLAG_RESET      = 3'h0;
  localparam logic [2:0]  MASK_RESET      = 3'h0;
  localparam logic [15:0] CMP_RESET       = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES    = 16'hFFFF;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // flag and mask layout: overflow bit 2, match 1 bit 1, match 0 bit 0
  typedef struct packed {
    logic overflow;
    logic match1;
    logic match0;
  } tmb_flags_s;

  typedef struct packed {
    logic sync_start;
    logic trig_falling;
    logic trig_start;
  } tmb_start_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_COUNTING
  } tmb_state_e;

endpackage : tmb_pkg

// ===== logic/tmb_prescaler.sv
// prescaler chain: peripheral clock select, divide, and counter source ticks
`timescale 1ns/1ns
module tmb_prescaler (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       gear_tick,
  input  wire logic       periph_src_sel,
  input  wire logic [2:0] divide_select,
  input  wire logic       run,
  input  wire logic [2:0] source_select,
  output logic            tick
);

  logic [4:0] div_cnt_ff;
  logic [7:0] psc_cnt_ff;
  logic       periph_tick;
  logic       phi0_tick;

  // ratio minus one for each divide code; codes above four act as /32
  function automatic logic [4:0] div_limit(input logic [2:0] sel);
    case (sel)
      3'h0:    div_limit = 5'h00;
      3'h1:    div_limit = 5'h01;
      3'h2:    div_limit = 5'h03;
      3'h3:    div_limit = 5'h07;
      3'h4:    div_limit = 5'h0F;
      default: div_limit = 5'h1F;
    endcase
  endfunction : div_limit

  // low-bit mask that must be all ones for each tap of the chain
  function automatic logic [7:0] tap_mask(input logic [2:0] sel);
    case (sel)
      3'h1:    tap_mask = 8'h00;
      3'h2:    tap_mask = 8'h03;
      3'h3:    tap_mask = 8'h0F;
      3'h4:    tap_mask = 8'h1F;
      3'h5:    tap_mask = 8'h3F;
      3'h6:    tap_mask = 8'h7F;
      default: tap_mask = 8'hFF;
    endcase
  endfunction : tap_mask

  // oscillator clock is the undivided system clock
  assign periph_tick = periph_src_sel ? 1'b1 : gear_tick;
  assign phi0_tick   = periph_tick && (div_cnt_ff == div_limit(divide_select));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_ff <= 5'h00;
    end else if (!run) begin
      div_cnt_ff <= 5'h00;
    end else if (phi0_tick) begin
      div_cnt_ff <= 5'h00;
    end else if (periph_tick) begin
      div_cnt_ff <= div_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_cnt_ff <= 8'h00;
    end else if (!run) begin
      psc_cnt_ff <= 8'h00;
    end else if (phi0_tick) begin
      psc_cnt_ff <= psc_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= run && phi0_tick && (source_select != tmb_pkg::SRC_EXTERNAL)
              && ((psc_cnt_ff & tap_mask(source_select)) == tap_mask(source_select));
    end
  end

endmodule : tmb_prescaler

// ===== logic/tmb_timer.sv
// sixteen-bit timer channel with its axi4-lite register slave
`timescale 1ns/1ns
module tmb_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_count_input,
  input  wire logic        gear_tick,
  input  wire logic        sync_master_run,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]             aw_addr_ff;
  logic                   aw_full_ff;
  logic [31:0]            w_data_ff;
  logic [3:0]             w_strb_ff;
  logic                   w_full_ff;
  logic                   wr_fire;
  logic                   rd_fire;
  logic [7:0]             wr_addr;
  logic [31:0]            rd_word;
  logic                   rd_hit;
  logic                   wr_hit;

  logic                   counter_run_ff;
  logic                   prescaler_run_ff;
  logic [2:0]             count_source_select_ff;
  logic                   ext_capture_en_ff;
  tmb_pkg::tmb_start_s    start_ff;
  logic [2:0]             prescaler_divide_select_ff;
  logic                   peripheral_source_select_ff;
  tmb_pkg::tmb_flags_s    event_status_ff;
  tmb_pkg::tmb_flags_s    nxt_event_status;
  tmb_pkg::tmb_flags_s    interrupt_mask_ff;
  tmb_pkg::tmb_flags_s    events;
  logic [15:0]            compare_value_a_ff;
  logic [15:0]            compare_value_b_ff;
  logic [15:0]            capture_value_a_ff;
  logic [15:0]            capture_value_b_ff;
  logic [15:0]            counter_snapshot_value_ff;
  logic [15:0]            up_counter_ff;
  logic [15:0]            counter_inc;
  tmb_pkg::tmb_state_e    state_ff;

  logic                   ext_meta_ff;
  logic                   ext_sync_ff;
  logic                   ext_prev_ff;
  logic                   ext_rise;
  logic                   ext_fall;
  logic                   trig_edge;
  logic                   run_request;
  logic                   presc_run;
  logic                   presc_tick;
  logic                   count_tick;
  logic                   soft_capture;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // merge a write into a 32-bit word under the byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    apply_strb = res;
  endfunction : apply_strb

  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction : zext16

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      tmb_pkg::OFS_RUN, tmb_pkg::OFS_MODE, tmb_pkg::OFS_START, tmb_pkg::OFS_CLKGEN,
      tmb_pkg::OFS_STATUS, tmb_pkg::OFS_MASK, tmb_pkg::OFS_SNAPSHOT, tmb_pkg::OFS_CMP0,
      tmb_pkg::OFS_CMP1, tmb_pkg::OFS_CAP0, tmb_pkg::OFS_CAP1: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order

  assign wr_fire = aw_full_ff && w_full_ff && !s_axi_bvalid;
  assign wr_addr = aw_addr_ff;
  assign wr_hit  = wr_fire && is_mapped(wr_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff    <= 1'b0;
      aw_addr_ff    <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_ff <= 1'b0;
      end
      s_axi_awready <= !aw_full_ff && !(s_axi_awvalid && s_axi_awready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_ff    <= 1'b0;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_ff <= 1'b0;
      end
      s_axi_wready <= !w_full_ff && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tmb_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(wr_addr) ? tmb_pkg::RESP_OKAY : tmb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // writable registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_run_ff   <= 1'b0;
      prescaler_run_ff <= 1'b0;
    end else if (wr_hit && wr_addr == tmb_pkg::OFS_RUN && w_strb_ff[0]) begin
      counter_run_ff   <= w_data_ff[tmb_pkg::RUN_COUNTER_BIT];
      prescaler_run_ff <= w_data_ff[tmb_pkg::RUN_PRESC_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_source_select_ff <= tmb_pkg::SRC_EXTERNAL;
      ext_capture_en_ff      <= 1'b0;
    end else if (wr_hit && wr_addr == tmb_pkg::OFS_MODE && w_strb_ff[0]) begin
      count_source_select_ff <= w_data_ff[tmb_pkg::MODE_SRC_LSB +: 3];
      ext_capture_en_ff      <= w_data_ff[tmb_pkg::MODE_EXTCAP_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= '0;
    end else if (wr_hit && wr_addr == tmb_pkg::OFS_START && w_strb_ff[0]) begin
      start_ff.trig_start   <= w_data_ff[tmb_pkg::START_TRIG_BIT];
      start_ff.trig_falling <= w_data_ff[tmb_pkg::START_FALL_BIT];
      start_ff.sync_start   <= w_data_ff[tmb_pkg::START_SYNC_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler_divide_select_ff  <= 3'h0;
      peripheral_source_select_ff <= 1'b0;
    end else if (wr_hit && wr_addr == tmb_pkg::OFS_CLKGEN && w_strb_ff[0]) begin
      prescaler_divide_select_ff  <= w_data_ff[tmb_pkg::CG_DIV_LSB +: 3];
      peripheral_source_select_ff <= w_data_ff[tmb_pkg::CG_SRC_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_mask_ff <= tmb_pkg::MASK_RESET;
    end else if (wr_hit && wr_addr == tmb_pkg::OFS_MASK && w_strb_ff[0]) begin
      interrupt_mask_ff <= w_data_ff[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_value_a_ff <= tmb_pkg::CMP_RESET;
      compare_value_b_ff <= tmb_pkg::CMP_RESET;
    end else if (wr_hit && wr_addr == tmb_pkg::OFS_CMP0) begin
      compare_value_a_ff <= 16'(apply_strb(zext16(compare_value_a_ff), w_data_ff,
                                           w_strb_ff));
    end else if (wr_hit && wr_addr == tmb_pkg::OFS_CMP1) begin
      compare_value_b_ff <= 16'(apply_strb(zext16(compare_value_b_ff), w_data_ff,
                                           w_strb_ff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // external pin: synchroniser and edge detection

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      ext_meta_ff <= external_count_input;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  assign ext_rise  = ext_sync_ff && !ext_prev_ff;
  assign ext_fall  = !ext_sync_ff && ext_prev_ff;
  assign trig_edge = start_ff.trig_falling ? ext_fall : ext_rise;

  ////////////////////////////////////////////////////////////////////////////////
  // counter source and start control

  // synchronous mode outranks the trigger mode and ignores the local counter run bit; the prescaler run bit still runs the prescaler
  assign run_request = start_ff.sync_start ? sync_master_run : counter_run_ff;
  assign presc_run   = prescaler_run_ff || (start_ff.sync_start && sync_master_run);

  tmb_prescaler u_prescaler (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .gear_tick      (gear_tick),
    .periph_src_sel (peripheral_source_select_ff),
    .divide_select  (prescaler_divide_select_ff),
    .run            (presc_run),
    .source_select  (count_source_select_ff),
    .tick           (presc_tick)
  );

  assign count_tick = (count_source_select_ff == tmb_pkg::SRC_EXTERNAL) ? ext_rise
                                                                        : presc_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= tmb_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        tmb_pkg::ST_IDLE: begin
          if (run_request) begin
            if (start_ff.trig_start && !start_ff.sync_start) begin
              state_ff <= tmb_pkg::ST_WAIT_TRIG;
            end else begin
              state_ff <= tmb_pkg::ST_COUNTING;
            end
          end
        end
        tmb_pkg::ST_WAIT_TRIG: begin
          if (!run_request) begin
            state_ff <= tmb_pkg::ST_IDLE;
          end else if (trig_edge) begin
            state_ff <= tmb_pkg::ST_COUNTING;
          end
        end
        tmb_pkg::ST_COUNTING: begin
          if (!run_request) begin
            state_ff <= tmb_pkg::ST_IDLE;
          end
        end
        default: state_ff <= tmb_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // up-counter, comparators and events

  assign counter_inc = up_counter_ff + 16'h0001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_counter_ff <= 16'h0000;
    end else if (!run_request) begin
      up_counter_ff <= 16'h0000;
    end else if (state_ff == tmb_pkg::ST_COUNTING && count_tick) begin
      up_counter_ff <= counter_inc;
    end
  end

  always_comb begin
    events = '0;
    if (run_request && state_ff == tmb_pkg::ST_COUNTING && count_tick) begin
      events.overflow = (up_counter_ff == tmb_pkg::CNT_ALL_ONES);
      events.match1   = (counter_inc == compare_value_b_ff);
      events.match0   = (counter_inc == compare_value_a_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // captures

  assign soft_capture = wr_hit && wr_addr == tmb_pkg::OFS_MODE && w_strb_ff[0]
                        && !w_data_ff[tmb_pkg::MODE_SOFTCAP_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_value_a_ff <= 16'h0000;
    end else if (soft_capture) begin
      capture_value_a_ff <= up_counter_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_value_b_ff <= 16'h0000;
    end else if (ext_capture_en_ff && ext_rise) begin
      capture_value_b_ff <= up_counter_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel and read side effects

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_hit  = is_mapped(s_axi_araddr);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      tmb_pkg::OFS_RUN: begin
        rd_word[tmb_pkg::RUN_COUNTER_BIT] = counter_run_ff;
        rd_word[tmb_pkg::RUN_PRESC_BIT]   = prescaler_run_ff;
      end
      tmb_pkg::OFS_MODE: begin
        rd_word[tmb_pkg::MODE_SRC_LSB +: 3]     = count_source_select_ff;
        rd_word[tmb_pkg::MODE_SOFTCAP_BIT]      = 1'b1;
        rd_word[tmb_pkg::MODE_EXTCAP_BIT]       = ext_capture_en_ff;
      end
      tmb_pkg::OFS_START:    rd_word[2:0] = start_ff;
      tmb_pkg::OFS_CLKGEN: begin
        rd_word[tmb_pkg::CG_DIV_LSB +: 3] = prescaler_divide_select_ff;
        rd_word[tmb_pkg::CG_SRC_BIT]      = peripheral_source_select_ff;
      end
      tmb_pkg::OFS_STATUS:   rd_word[2:0] = event_status_ff;
      tmb_pkg::OFS_MASK:     rd_word[2:0] = interrupt_mask_ff;
      // while counting the live value is returned, otherwise the last snapshot
      tmb_pkg::OFS_SNAPSHOT: rd_word = zext16((state_ff == tmb_pkg::ST_COUNTING)
                                              ? up_counter_ff
                                              : counter_snapshot_value_ff);
      tmb_pkg::OFS_CMP0:     rd_word = zext16(compare_value_a_ff);
      tmb_pkg::OFS_CMP1:     rd_word = zext16(compare_value_b_ff);
      tmb_pkg::OFS_CAP0:     rd_word = zext16(capture_value_a_ff);
      tmb_pkg::OFS_CAP1:     rd_word = zext16(capture_value_b_ff);
      default:               rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tmb_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? tmb_pkg::RESP_OKAY : tmb_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_snapshot_value_ff <= 16'h0000;
    end else if (rd_fire && s_axi_araddr == tmb_pkg::OFS_SNAPSHOT
                 && state_ff == tmb_pkg::ST_COUNTING) begin
      counter_snapshot_value_ff <= up_counter_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event flags and interrupt

  // a new event in the clearing read's cycle survives the clear
  always_comb begin
    nxt_event_status = event_status_ff;
    if (rd_fire && s_axi_araddr == tmb_pkg::OFS_STATUS) begin
      nxt_event_status = tmb_pkg::FLAG_RESET;
    end
    nxt_event_status = nxt_event_status | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_status_ff <= tmb_pkg::FLAG_RESET;
    end else begin
      event_status_ff <= nxt_event_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_event_status & interrupt_mask_ff);
    end
  end

endmodule : tmb_timer

// ===== tb/tmb_timer_props.sv
// register bus checks for the timer channel
`timescale 1ns/1ns
module tmb_timer_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  a_unmapped_rd: assert property (s_ar_take ##0 s_axi_araddr > 8'h28 |=>
    s_axi_rresp == tmb_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answered");
  a_mapped_rd: assert property (s_ar_take ##0 s_axi_araddr <= 8'h28 |=>
    s_axi_rresp == tmb_pkg::RESP_OKAY) else $error("mapped read refused");
endmodule : tmb_timer_props
bind tmb_timer tmb_timer_props u_tmb_timer_props (.*);

// ===== tb/tmb_ext_pin.sv
// external count pin: bursts of clean pulses, low between bursts
`timescale 1ns/1ns
module tmb_ext_pin (
  input wire logic       aclk,
  input wire logic       go,
  input wire logic [7:0] n,
  output logic           pin
);
  logic [7:0] left_ff = 8'h00;
  logic [2:0] ph_ff = 3'h0;
  always_ff @(posedge aclk) begin
    if (go) begin
      left_ff <= n;
      ph_ff <= 3'h0;
    end else if (left_ff != 8'h00) begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h7) left_ff <= left_ff - 8'h01;
    end
  end
  // four cycles low then four high per pulse
  assign pin = (left_ff != 8'h00) && ph_ff[2];
endmodule : tmb_ext_pin

// ===== tb/tb.sv
// self-checking bench for the timer channel
`timescale 1ns/1ns
module tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, gear_tick = 0, sync_master_run = 0, go = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic external_count_input;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, n_pulse = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, dat, s1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_mismatch = 0, cmp_count = 0, mdl[int];
  int ra[3] = '{32'h14, 32'h1c, 32'h20}, rm[3] = '{32'h7, 32'hffff, 32'hffff};
  always #10 aclk = ~aclk;
  always @(posedge aclk) gear_tick <= 1'($urandom_range(0, 1));
  tmb_timer u_tmb_timer (.*);
  tmb_ext_pin u_tmb_ext_pin (.aclk, .go, .n(n_pulse), .pin(external_count_input));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h86b8_27e3));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    for (int a = 32'h10; a <= 32'h28; a += 4) begin
      rd(8'(a));
      chk("reset value", dat, 32'h0000_0000);
    end
    rd(8'h2c);
    chk("unmapped resp", 32'(rsp), 32'(tmb_pkg::RESP_SLVERR));
    wr(8'h2c, 32'h0000_0001);
    chk("unmapped wr resp", 32'(rsp), 32'(tmb_pkg::RESP_SLVERR));
    for (int i = 0; i < 3; i++) begin
      s1 = $urandom;
      wr(8'(ra[i]), s1);
      mdl[ra[i]] = s1 & rm[i];
      rd(8'(ra[i]));
      chk("read back", dat, 32'(mdl[ra[i]]));
    end
    wr(8'h1c, 32'd30);
    wr(8'h20, 32'd50);
    wr(8'h0c, 32'h0000_0010);
    wr(8'h04, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'h0000_0004);
      rd(8'h10);
      wr(8'h14, 32'(1 << i));
      wr(8'h00, 32'h0000_0005);
      for (int k = 0; k < 70000 && irq !== 1'b1; k++) @(posedge aclk);
      chk("irq raised", irq, 1);
      rd(8'h10);
      chk("event flags", dat, 32'((1 << (i + 1)) - 1));
      repeat (2) @(posedge aclk);
      chk("irq cleared", irq, 0);
    end
    rd(8'h18);
    s1 = dat;
    rd(8'h18);
    chk("snapshot advances", dat > s1, 1);
    s1 = dat;
    wr(8'h00, 32'h0000_0004);
    rd(8'h18);
    chk("snapshot held", dat, s1);
    wr(8'h00, 32'h0000_0005);
    rd(8'h18);
    chk("counter cleared", dat < 16, 1);
    wr(8'h00, 32'h0000_0004);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0005);
    go <= 1;
    n_pulse <= 8'd5;
    @(posedge aclk);
    go <= 0;
    repeat (60) @(posedge aclk);
    rd(8'h18);
    chk("external count", dat, 32'd5);
    wr(8'h00, 32'h0000_0004);
    wr(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    wr(8'h14, 32'h0000_0001);
    rd(8'h10);
    wr(8'h00, 32'h0000_0005);
    repeat (100) @(posedge aclk);
    chk("trigger wait", irq, 0);
    go <= 1;
    n_pulse <= 8'd1;
    @(posedge aclk);
    go <= 0;
    for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge aclk);
    chk("trigger start", irq, 1);
    wr(8'h04, 32'h0000_0001);
    rd(8'h24);
    s1 = dat;
    rd(8'h18);
    chk("soft capture", s1 > 0 && s1 < dat, 1);
    wr(8'h00, 32'h0000_0000);
    wr(8'h08, 32'h0000_0004);
    rd(8'h10);
    sync_master_run <= 1;
    for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge aclk);
    chk("sync start", irq, 1);
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge aclk);
    n_mismatch++;
    wrap_up();
  end
endmodule : tb
